// file: logic/smc_standby_ctrl.sv
/*
 * Standby mode controller: mode sequencer, clock gate outputs and the
 * AXI4-Lite register slave that configures them.
 * Assumes halt, doze, wake and DMA request come from logic on i_clk.
 */
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module smc_standby_ctrl #(
    parameter int unsigned AW = 8,
    parameter int unsigned WARMUP_CYCLES = smc_pkg::WARMUP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [AW-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [AW-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_halt_req,
    input wire logic i_doze_req,
    input wire logic i_wake_irq,
    input wire logic i_dma_bus_req,
    output logic o_cpu_clk_en,
    output logic o_fast_osc_en,
    output logic o_slow_osc_en,
    output logic o_pll_en,
    output logic [smc_pkg::NPERIPH-1:0] o_periph_clk_en,
    output logic o_rtc_clk_en,
    output logic o_pulse_cnt_clk_en,
    output logic o_key_wakeup_pullup_clk_en,
    output logic o_interrupt_controller_unit_clk_en,
    output logic o_external_bus_interface_unit_clk_en,
    output logic o_parallel_ports_clk_en,
    output logic o_dma_clk_en,
    output logic o_dma_bus_grant
);

    localparam int unsigned NP = smc_pkg::NPERIPH;
    localparam int unsigned WCW = $clog2(WARMUP_CYCLES);
    localparam logic [WCW-1:0] WARM_LAST = WCW'(WARMUP_CYCLES - 1);

    typedef struct packed {
        smc_pkg::smc_mode_t mode;
        logic [WCW-1:0] wcnt;
        logic halt_q;
        logic doze_q;
        logic [1:0] sel;
        logic slow;
        logic [NP-1:0] idle_run;
        logic awready;
        logic wready;
        logic have_aw;
        logic have_w;
        logic [AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic cpu_en;
        logic fosc_en;
        logic fs_en;
        logic pll_en;
        logic [NP-1:0] periph_en;
        logic rtc_en;
        logic pcnt_en;
        logic key_wakeup_pullup_en;
        logic interrupt_controller_unit_en;
        logic external_bus_interface_unit_en;
        logic pio_en;
        logic dma_en;
        logic dma_grant;
    } smc_state_t;

    smc_state_t s_r;
    smc_state_t s_nxt;
    logic halt_rise;
    logic doze_rise;
    logic [31:0] wword;

    ////////////////////////////////////////////////////////////////////////
    // Register decode helpers

    function automatic logic addr_hit(input logic [AW-1:0] a, input logic [7:0] off);
        addr_hit = (a[AW-1:2] == off[AW-1:2]);
    endfunction

    function automatic logic addr_ok(input logic [AW-1:0] a);
        addr_ok = addr_hit(a, smc_pkg::CTRL_OFF) || addr_hit(a, smc_pkg::IDLE_RUN_OFF)
            || addr_hit(a, smc_pkg::STATUS_OFF);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
            input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[8*i +: 8] = d[8*i +: 8];
            end
        end
    endfunction

    function automatic logic [31:0] ctrl_word(input smc_state_t s);
        ctrl_word = 32'h00000000;
        ctrl_word[smc_pkg::SEL_LSB +: 2] = s.sel;
        ctrl_word[smc_pkg::SLOW_BIT] = s.slow;
    endfunction

    function automatic logic [31:0] read_word(input smc_state_t s, input logic [AW-1:0] a);
        read_word = 32'h00000000;
        if (addr_hit(a, smc_pkg::CTRL_OFF)) begin
            read_word = ctrl_word(s);
        end else if (addr_hit(a, smc_pkg::IDLE_RUN_OFF)) begin
            read_word[NP-1:0] = s.idle_run;
        end else if (addr_hit(a, smc_pkg::STATUS_OFF)) begin
            read_word[smc_pkg::ST_WARMUP_BIT] = (s.mode == smc_pkg::M_WARMUP);
            read_word[smc_pkg::ST_NORMAL_BIT] = (s.mode == smc_pkg::M_NORMAL);
            read_word[smc_pkg::ST_SLOW_BIT] = (s.mode == smc_pkg::M_SLOW);
            read_word[smc_pkg::ST_IDLE_HALT_BIT] = (s.mode == smc_pkg::M_IDLE_HALT);
            read_word[smc_pkg::ST_IDLE_DOZE_BIT] = (s.mode == smc_pkg::M_IDLE_DOZE);
            read_word[smc_pkg::ST_SLEEP_BIT] = (s.mode == smc_pkg::M_SLEEP);
            read_word[smc_pkg::ST_STOP_BIT] = (s.mode == smc_pkg::M_STOP);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt = s_r;
        wword = 32'h00000000;
        // Edges only, so a request still high after wake-up does not re-enter
        halt_rise = i_halt_req && !s_r.halt_q;
        doze_rise = i_doze_req && !s_r.doze_q;
        s_nxt.halt_q = i_halt_req;
        s_nxt.doze_q = i_doze_req;

        case (s_r.mode)
            smc_pkg::M_WARMUP: begin
                if (s_r.wcnt == WARM_LAST) begin
                    s_nxt.mode = smc_pkg::M_NORMAL;
                    s_nxt.wcnt = '0;
                end else begin
                    s_nxt.wcnt = s_r.wcnt + WCW'(1);
                end
            end
            smc_pkg::M_NORMAL: begin
                if (doze_rise) begin
                    s_nxt.mode = smc_pkg::M_IDLE_DOZE;
                end else if (halt_rise) begin
                    case (s_r.sel)
                        smc_pkg::SEL_STOP: s_nxt.mode = smc_pkg::M_STOP;
                        smc_pkg::SEL_SLEEP: s_nxt.mode = smc_pkg::M_SLEEP;
                        default: s_nxt.mode = smc_pkg::M_IDLE_HALT;
                    endcase
                end else if (s_r.slow) begin
                    s_nxt.mode = smc_pkg::M_SLOW;
                end
            end
            smc_pkg::M_SLOW: begin
                if (doze_rise) begin
                    s_nxt.mode = smc_pkg::M_IDLE_DOZE;
                end else if (!s_r.slow) begin
                    s_nxt.mode = smc_pkg::M_NORMAL;
                end
            end
            smc_pkg::M_IDLE_HALT, smc_pkg::M_IDLE_DOZE: begin
                if (i_wake_irq) begin
                    s_nxt.mode = smc_pkg::M_NORMAL;
                end
            end
            smc_pkg::M_SLEEP, smc_pkg::M_STOP: begin
                // Oscillator was off or slow only, so settle it again
                if (i_wake_irq) begin
                    s_nxt.mode = smc_pkg::M_WARMUP;
                    s_nxt.wcnt = '0;
                end
            end
            default: begin
                s_nxt.mode = smc_pkg::M_WARMUP;
                s_nxt.wcnt = '0;
            end
        endcase

        // Clock gates follow the mode being entered
        s_nxt.cpu_en = 1'b0;
        s_nxt.fosc_en = 1'b1;
        s_nxt.fs_en = 1'b1;
        s_nxt.pll_en = 1'b1;
        s_nxt.periph_en = '0;
        s_nxt.rtc_en = 1'b0;
        s_nxt.pcnt_en = 1'b0;
        s_nxt.key_wakeup_pullup_en = 1'b0;
        s_nxt.interrupt_controller_unit_en = 1'b0;
        s_nxt.external_bus_interface_unit_en = 1'b0;
        s_nxt.pio_en = 1'b0;
        s_nxt.dma_en = 1'b0;
        s_nxt.dma_grant = 1'b0;
        case (s_nxt.mode)
            smc_pkg::M_NORMAL: begin
                s_nxt.cpu_en = 1'b1;
                s_nxt.periph_en = '1;
                s_nxt.rtc_en = 1'b1;
                s_nxt.pcnt_en = 1'b1;
                s_nxt.key_wakeup_pullup_en = 1'b1;
                s_nxt.interrupt_controller_unit_en = 1'b1;
                s_nxt.external_bus_interface_unit_en = 1'b1;
                s_nxt.pio_en = 1'b1;
                s_nxt.dma_en = 1'b1;
            end
            smc_pkg::M_SLOW: begin
                s_nxt.cpu_en = 1'b1;
                s_nxt.pll_en = 1'b0;
                s_nxt.periph_en[smc_pkg::WDT_BIT] = 1'b1;
                s_nxt.rtc_en = 1'b1;
                s_nxt.interrupt_controller_unit_en = 1'b1;
                s_nxt.external_bus_interface_unit_en = 1'b1;
                s_nxt.pio_en = 1'b1;
            end
            smc_pkg::M_IDLE_HALT, smc_pkg::M_IDLE_DOZE: begin
                s_nxt.periph_en = s_r.idle_run;
                s_nxt.rtc_en = 1'b1;
                s_nxt.pcnt_en = 1'b1;
                s_nxt.key_wakeup_pullup_en = 1'b1;
                s_nxt.interrupt_controller_unit_en = 1'b1;
                s_nxt.external_bus_interface_unit_en = 1'b1;
                if (s_nxt.mode == smc_pkg::M_IDLE_DOZE) begin
                    s_nxt.pio_en = 1'b1;
                    s_nxt.dma_en = 1'b1;
                    s_nxt.dma_grant = i_dma_bus_req;
                end
                // Halt idle leaves grant low whatever DMA asks
            end
            smc_pkg::M_SLEEP: begin
                s_nxt.fosc_en = 1'b0;
                s_nxt.pll_en = 1'b0;
                s_nxt.rtc_en = 1'b1;
                s_nxt.pcnt_en = 1'b1;
                s_nxt.key_wakeup_pullup_en = 1'b1;
            end
            smc_pkg::M_STOP: begin
                s_nxt.fosc_en = 1'b0;
                s_nxt.fs_en = 1'b0;
                s_nxt.pll_en = 1'b0;
            end
            default: begin
                // Warm-up: oscillators and PLL settle, nothing clocked
            end
        endcase

        // Write channel
        if (s_r.bvalid && i_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (i_awvalid && s_r.awready) begin
            s_nxt.have_aw = 1'b1;
            s_nxt.awaddr = i_awaddr;
        end
        if (i_wvalid && s_r.wready) begin
            s_nxt.have_w = 1'b1;
            s_nxt.wdata = i_wdata;
            s_nxt.wstrb = i_wstrb;
        end
        if (s_nxt.have_aw && s_nxt.have_w && !s_nxt.bvalid) begin
            s_nxt.have_aw = 1'b0;
            s_nxt.have_w = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = addr_ok(s_nxt.awaddr) ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
            if (addr_hit(s_nxt.awaddr, smc_pkg::CTRL_OFF)) begin
                wword = merge(ctrl_word(s_r), s_nxt.wdata, s_nxt.wstrb);
                s_nxt.sel = wword[smc_pkg::SEL_LSB +: 2];
                s_nxt.slow = wword[smc_pkg::SLOW_BIT];
            end else if (addr_hit(s_nxt.awaddr, smc_pkg::IDLE_RUN_OFF)) begin
                wword = merge(32'(s_r.idle_run), s_nxt.wdata, s_nxt.wstrb);
                s_nxt.idle_run = wword[NP-1:0];
            end
        end
        s_nxt.awready = !s_nxt.have_aw && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.have_w && !s_nxt.bvalid;

        // Read channel
        if (s_r.rvalid && i_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (i_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = read_word(s_r, i_araddr);
            s_nxt.rresp = addr_ok(i_araddr) ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
        end
        s_nxt.arready = !s_nxt.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // All zero: warm-up, count zero, gates closed, select and idle bits cleared
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_awready = s_r.awready;
    assign o_wready = s_r.wready;
    assign o_bresp = s_r.bresp;
    assign o_bvalid = s_r.bvalid;
    assign o_arready = s_r.arready;
    assign o_rdata = s_r.rdata;
    assign o_rresp = s_r.rresp;
    assign o_rvalid = s_r.rvalid;
    assign o_cpu_clk_en = s_r.cpu_en;
    assign o_fast_osc_en = s_r.fosc_en;
    assign o_slow_osc_en = s_r.fs_en;
    assign o_pll_en = s_r.pll_en;
    assign o_periph_clk_en = s_r.periph_en;
    assign o_rtc_clk_en = s_r.rtc_en;
    assign o_pulse_cnt_clk_en = s_r.pcnt_en;
    assign o_key_wakeup_pullup_clk_en = s_r.key_wakeup_pullup_en;
    assign o_interrupt_controller_unit_clk_en = s_r.interrupt_controller_unit_en;
    assign o_external_bus_interface_unit_clk_en = s_r.external_bus_interface_unit_en;
    assign o_parallel_ports_clk_en = s_r.pio_en;
    assign o_dma_clk_en = s_r.dma_en;
    assign o_dma_bus_grant = s_r.dma_grant;

endmodule

`default_nettype wire

// file: logic/smc_pkg.sv
/*
 * Constants and types shared by the standby mode controller.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none

package smc_pkg;

    // Peripheral clock gate vector layout
    localparam int unsigned NPERIPH = 28;
    localparam int unsigned TA_LSB = 0;
    localparam int unsigned TA_NUM = 6;
    localparam int unsigned TB_LSB = 6;
    localparam int unsigned TB_NUM = 14;
    localparam int unsigned SIO_LSB = 20;
    localparam int unsigned SIO_NUM = 5;
    localparam int unsigned SBI_BIT = 25;
    localparam int unsigned ADC_BIT = 26;
    localparam int unsigned WDT_BIT = 27;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] IDLE_RUN_OFF = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;

    // Control register fields
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned SLOW_BIT = 2;
    localparam logic [1:0] SEL_STOP = 2'h1;
    localparam logic [1:0] SEL_SLEEP = 2'h2;
    localparam logic [1:0] SEL_IDLE = 2'h3;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [NPERIPH-1:0] IDLE_RUN_RST = 28'h0000000;

    // Status register bits, one per mode
    localparam int unsigned ST_WARMUP_BIT = 0;
    localparam int unsigned ST_NORMAL_BIT = 1;
    localparam int unsigned ST_SLOW_BIT = 2;
    localparam int unsigned ST_IDLE_HALT_BIT = 3;
    localparam int unsigned ST_IDLE_DOZE_BIT = 4;
    localparam int unsigned ST_SLEEP_BIT = 5;
    localparam int unsigned ST_STOP_BIT = 6;

    // Warm-up after reset, in oscillator periods (one clock each)
    localparam int unsigned WARMUP_EXP = 14;
    localparam int unsigned WARMUP_CYCLES = 1 << WARMUP_EXP;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Warm-up first so that an all-zero reset lands there
    typedef enum logic [2:0] {
        M_WARMUP,
        M_NORMAL,
        M_SLOW,
        M_IDLE_HALT,
        M_IDLE_DOZE,
        M_SLEEP,
        M_STOP
    } smc_mode_t;

endpackage

`default_nettype wire

// file: tb/smc_standby_asserts.sv
/* Checker on the standby controller's gate outputs.
   Bound to smc_standby_ctrl from the bench top; one clock. */
`timescale 1ns/1ps
`default_nettype none
module smc_standby_asserts (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_halt_req,
    input wire logic i_doze_req,
    input wire logic i_dma_bus_req,
    input wire logic o_cpu_clk_en,
    input wire logic o_fast_osc_en,
    input wire logic o_slow_osc_en,
    input wire logic o_pll_en,
    input wire logic [27:0] o_periph_clk_en,
    input wire logic o_rtc_clk_en,
    input wire logic o_pulse_cnt_clk_en,
    input wire logic o_key_wakeup_pullup_clk_en,
    input wire logic o_interrupt_controller_unit_clk_en,
    input wire logic o_external_bus_interface_unit_clk_en,
    input wire logic o_parallel_ports_clk_en,
    input wire logic o_dma_clk_en,
    input wire logic o_dma_bus_grant
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
////////////////////////////////////////////////////////////////////////
    halt_enter_a: assert property (
        o_cpu_clk_en && o_pll_en && $rose(i_halt_req) && !i_doze_req |=> !o_cpu_clk_en)
        else $error("halt in normal did not stop the processor");
    doze_idle_a: assert property (
        o_cpu_clk_en && $rose(i_doze_req) |=> !o_cpu_clk_en && o_fast_osc_en && o_pll_en)
        else $error("doze did not enter idle");
    idle_core_on_a: assert property (
        !o_cpu_clk_en && o_pll_en && o_rtc_clk_en |-> o_interrupt_controller_unit_clk_en && o_external_bus_interface_unit_clk_en
        && o_pulse_cnt_clk_en && o_key_wakeup_pullup_clk_en)
        else $error("idle stopped more than the processor");
    halt_no_grant_a: assert property (
        !o_cpu_clk_en && o_pll_en && !o_parallel_ports_clk_en |-> !o_dma_bus_grant)
        else $error("bus granted in halt idle");
    grant_follow_a: assert property (
        o_dma_clk_en && !o_cpu_clk_en |-> o_dma_bus_grant == $past(i_dma_bus_req))
        else $error("doze grant does not follow request");
    sleep_gates_a: assert property (
        o_slow_osc_en && !o_fast_osc_en |-> o_rtc_clk_en && o_pulse_cnt_clk_en
        && o_key_wakeup_pullup_clk_en && !o_pll_en && !o_cpu_clk_en && o_periph_clk_en == 28'h0)
        else $error("sleep gates wrong");
    stop_all_off_a: assert property (
        !o_slow_osc_en |-> !o_fast_osc_en && !o_pll_en && !o_rtc_clk_en && !o_cpu_clk_en
        && o_periph_clk_en == 28'h0 && !o_key_wakeup_pullup_clk_en)
        else $error("stop left a clock running");
    slow_gates_a: assert property (
        o_cpu_clk_en && !o_pll_en |-> o_periph_clk_en == 28'h8000000 && o_interrupt_controller_unit_clk_en
        && o_external_bus_interface_unit_clk_en && o_parallel_ports_clk_en && o_rtc_clk_en && !o_dma_clk_en)
        else $error("slow gates wrong");
endmodule
`default_nettype wire

// file: tb/smc_core_model.sv
/* Processor core model: raises halt, doze, wake and DMA requests.
   Assumes commands from the bench, same clock as the controller. */
`timescale 1ns/1ps
`default_nettype none
module smc_core_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cfg_done,
    input wire logic i_halt,
    input wire logic i_doze,
    input wire logic i_wake,
    input wire logic i_dma,
    output logic o_halt_req,
    output logic o_doze_req,
    output logic o_wake_irq,
    output logic o_dma_bus_req
);
    // Halt and doze requests held back until software has set the block up; wake and DMA are registered without that gate
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_halt_req <= 1'b0;
            o_doze_req <= 1'b0;
            o_wake_irq <= 1'b0;
            o_dma_bus_req <= 1'b0;
        end else begin
            o_halt_req <= i_halt & i_cfg_done;
            o_doze_req <= i_doze & i_cfg_done;
            o_wake_irq <= i_wake;
            o_dma_bus_req <= i_dma;
        end
    end
endmodule
`default_nettype wire

// file: tb/standby_mode_control_test.sv
/* Bench for the standby controller: AXI4-Lite tasks, a core model
   and one task per scenario. Assumes a warm-up count of 8. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module standby_mode_control_test;
    localparam logic [1:0] OK = smc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = smc_pkg::RESP_SLVERR;
    logic clk, rst_b, awv, wv, arv, halt_c, doze_c, wake_c, dma_c, cfg_c;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd;
    logic [1:0] br, rr;
    logic awr, wrdy, arr, bv, rv, halt, doze, wake, dma;
    logic cpu, fo, so, pll, rtc, pc, kw, ic, eb, parallel_ports, dc, gr;
    logic [27:0] per;
    wire logic [11:0] g;
    int error_cnt, comparisons, cyc;
    assign g = {cpu, fo, so, pll, rtc, pc, kw, ic, eb, parallel_ports, dc, gr};
////////////////////////////////////////////////////////////////////////
    smc_core_model i_core (.i_clk(clk), .i_rst_b(rst_b), .i_cfg_done(cfg_c),
        .i_halt(halt_c), .i_doze(doze_c), .i_wake(wake_c), .i_dma(dma_c),
        .o_halt_req(halt), .o_doze_req(doze), .o_wake_irq(wake), .o_dma_bus_req(dma));
    smc_standby_ctrl #(.WARMUP_CYCLES(8)) i_dut (.i_clk(clk), .i_rst_b(rst_b),
        .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF),
        .i_wvalid(wv), .o_wready(wrdy), .o_bresp(br), .o_bvalid(bv), .i_bready(1'b1),
        .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd), .o_rresp(rr),
        .o_rvalid(rv), .i_rready(1'b1), .i_halt_req(halt), .i_doze_req(doze),
        .i_wake_irq(wake), .i_dma_bus_req(dma), .o_cpu_clk_en(cpu), .o_fast_osc_en(fo),
        .o_slow_osc_en(so), .o_pll_en(pll), .o_periph_clk_en(per), .o_rtc_clk_en(rtc),
        .o_pulse_cnt_clk_en(pc), .o_key_wakeup_pullup_clk_en(kw), .o_interrupt_controller_unit_clk_en(ic),
        .o_external_bus_interface_unit_clk_en(eb), .o_parallel_ports_clk_en(parallel_ports), .o_dma_clk_en(dc),
        .o_dma_bus_grant(gr));
////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Ready lines are always high, so a response is taken when seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        forever begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        `CHK("bresp", er, br)
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        ara <= a;
        arv <= 1'b1;
        forever begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        `CHK("rresp", er, rr)
        `CHK("rdata", ed, rd)
    endtask
    task automatic gates(input logic [11:0] eg, input logic [27:0] ep);
        `CHK("gates", eg, g)
        `CHK("periph", ep, per)
    endtask
    task automatic enter(input logic [31:0] ctrl, input logic dz);
        wr(smc_pkg::CTRL_OFF, ctrl, OK);
        cfg_c <= 1'b1;
        if (dz) doze_c <= 1'b1;
        else halt_c <= 1'b1;
        tick(4);
    endtask
    task automatic leave();
        halt_c <= 1'b0;
        doze_c <= 1'b0;
        cfg_c <= 1'b0;
        wake_c <= 1'b1;
        tick(2);
        wake_c <= 1'b0;
        tick(1);
    endtask
////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        tick(2);
        gates(12'h700, 28'h0);
        tick(10);
        gates(12'hFFE, 28'hFFFFFFF);
        rdc(8'h0C, 32'h0, ERR);
        wr(8'h0C, 32'hFFFFFFFF, ERR);
        rdc(smc_pkg::CTRL_OFF, 32'h0, OK);
    endtask
    task automatic t_halt_idle();
        wr(smc_pkg::IDLE_RUN_OFF, 32'h0A5C3E69, OK);
        enter(32'h3, 1'b0);
        gates(12'h7F8, 28'hA5C3E69);
        rdc(smc_pkg::STATUS_OFF, 32'h8, OK);
        leave();
        gates(12'hFFE, 28'hFFFFFFF);
    endtask
    task automatic t_doze();
        wr(smc_pkg::IDLE_RUN_OFF, 32'h05A3C196, OK);
        enter(32'h1, 1'b1);
        gates(12'h7FF, 28'h5A3C196);
        // Drop the DMA request so the grant has to follow it down
        dma_c <= 1'b0;
        tick(3);
        gates(12'h7FE, 28'h5A3C196);
        dma_c <= 1'b1;
        leave();
    endtask
    task automatic t_sleep_stop();
        enter(32'h2, 1'b0);
        gates(12'h2E0, 28'h0);
        rdc(smc_pkg::STATUS_OFF, 32'h20, OK);
        leave();
        gates(12'h700, 28'h0);
        tick(10);
        enter(32'h1, 1'b0);
        gates(12'h000, 28'h0);
        leave();
        tick(10);
        gates(12'hFFE, 28'hFFFFFFF);
    endtask
    // Halt while slow must be ignored
    task automatic t_slow();
        wr(smc_pkg::CTRL_OFF, 32'h4, OK);
        cfg_c <= 1'b1;
        halt_c <= 1'b1;
        tick(4);
        gates(12'hE9C, 28'h8000000);
        wr(smc_pkg::CTRL_OFF, 32'h0, OK);
        halt_c <= 1'b0;
        tick(3);
        gates(12'hFFE, 28'hFFFFFFF);
    endtask
    // Reset in mid-run: idle bits must clear and warm-up start again
    task automatic t_mid_reset();
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        tick(2);
        gates(12'h700, 28'h0);
        tick(8);
        gates(12'hFFE, 28'hFFFFFFF);
        rdc(smc_pkg::IDLE_RUN_OFF, 32'h0, OK);
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        {rst_b, awv, wv, arv, halt_c, doze_c, wake_c, cfg_c, awa, ara, wd} = '0;
        dma_c = 1'b1;
        error_cnt = 0;
        comparisons = 0;
        cyc = 0;
        tick(10);
        rst_b <= 1'b1;
        t_reset();
        t_halt_idle();
        t_doze();
        t_sleep_stop();
        t_slow();
        t_mid_reset();
        close_out();
    end
endmodule
bind smc_standby_ctrl smc_standby_asserts i_chk (.i_clk, .i_rst_b, .i_halt_req, .i_doze_req,
    .i_dma_bus_req, .o_cpu_clk_en, .o_fast_osc_en, .o_slow_osc_en, .o_pll_en, .o_periph_clk_en,
    .o_rtc_clk_en, .o_pulse_cnt_clk_en, .o_key_wakeup_pullup_clk_en, .o_interrupt_controller_unit_clk_en,
    .o_external_bus_interface_unit_clk_en, .o_parallel_ports_clk_en, .o_dma_clk_en, .o_dma_bus_grant);
`default_nettype wire
